// ===== rtl/packed_simd_integer_alu.sv
//----------------------------------------------------------------------
// Purpose: 64-bit packed integer SIMD execution datapath
// Assumes: requests are decoded; one result per request, one cycle later
// Notes:   lane math is a parameterised lane module, one copy per lane
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "packed_simd_consts.svh"

//----------------------------------------------------------------------
// lane module
//----------------------------------------------------------------------
module simd_lane #(
    parameter int W = 8
) (
    input wire logic [W-1:0] x,
    input wire logic [W-1:0] y,
    input wire packed_simd_pkg::op_kind_type kind,
    input wire packed_simd_pkg::ovf_mode_type mode,
    input wire logic [7:0] cnt,
    output logic [W-1:0] r
);
    import packed_simd_pkg::*;

    logic sgn;
    logic [W+1:0] xe;
    logic [W+1:0] ye;
    logic [W+1:0] s;
    logic pos_ovf;
    logic neg_ovf;
    logic [W-1:0] arith;
    logic big;
    logic [W-1:0] fill;

    // operands widened inside the lane only, so carries stay here
    assign sgn = (mode == mode_sat_signed);
    assign xe = {{2{sgn & x[W-1]}}, x};
    assign ye = {{2{sgn & y[W-1]}}, y};
    assign s = (kind == op_sub) ? xe - ye : xe + ye;
    // overflow detection per mode
    assign pos_ovf = sgn ? (!s[W+1] && s[W-1]) : s[W] && !s[W+1];
    assign neg_ovf = sgn ? (s[W+1] && !s[W-1]) : s[W+1];
    assign fill = {W{1'b1}};
    assign big = (cnt >= 8'(W));

    // clamp or truncate the sum, never reporting the overflow
    always_comb begin
        arith = s[W-1:0];
        if (mode == mode_sat_signed) begin
            if (pos_ovf) arith = fill >> 1;
            else if (neg_ovf) arith = ~(fill >> 1);
        end else if (mode == mode_sat_unsigned) begin
            if (neg_ovf) arith = '0;
            else if (pos_ovf) arith = fill;
        end
    end

    // per-lane result select
    always_comb begin
        case (kind)
            op_add, op_sub: r = arith;
            op_cmp_eq: r = (x == y) ? fill : '0;
            op_cmp_gt: r = ($signed(x) > $signed(y)) ? fill : '0;
            op_shl: r = big ? '0 : x << cnt;
            op_shr_logic: r = big ? '0 : x >> cnt;
            op_shr_arith: r = $unsigned($signed(x) >>> cnt);
            default: r = '0;
        endcase
    end
endmodule // simd_lane

//----------------------------------------------------------------------
// top module
//----------------------------------------------------------------------
module packed_simd_integer_alu #(
    parameter int DATA_W = `SIMD_DATA_W
) (
    input wire logic mclk,
    input wire logic srst,
    input packed_simd_pkg::simd_req_type req,
    output packed_simd_pkg::simd_rsp_type rsp,
    output logic flags_update,
    output logic vector_state_empty,
    output logic [`SIMD_FEATURE_W-1:0] feature_word,
    output logic [7:0] op_count
);
    import packed_simd_pkg::*;

    if (DATA_W != 64) begin : g_width_check
        $error("packed datapath serves 64-bit only");
    end

    logic [7:0][7:0] r8;
    logic [3:0][15:0] r16;
    logic [1:0][31:0] r32;
    logic [63:0] r64;
    logic [63:0] lane_res;
    logic [63:0] misc_res;
    logic [63:0] result_next;
    logic [63:0] load_val;
    logic sat_illegal;
    logic illegal_next;
    logic lane_kind;
    simd_rsp_type rsp_reg;
    logic empty_reg;

    //------------------------------------------------------------------
    // lane arrays
    //------------------------------------------------------------------
    // one lane copy per element; all run in parallel
    for (genvar i = 0; i < 8; i++) begin : g_byte
        simd_lane #(.W(8)) u_lane (
            .x(req.src_a[8*i +: 8]), .y(req.src_b[8*i +: 8]),
            .kind(req.kind), .mode(req.mode), .cnt(req.shift_count),
            .r(r8[i])
        );
    end
    for (genvar i = 0; i < 4; i++) begin : g_word
        simd_lane #(.W(16)) u_lane (
            .x(req.src_a[16*i +: 16]), .y(req.src_b[16*i +: 16]),
            .kind(req.kind), .mode(req.mode), .cnt(req.shift_count),
            .r(r16[i])
        );
    end
    for (genvar i = 0; i < 2; i++) begin : g_dword
        simd_lane #(.W(32)) u_lane (
            .x(req.src_a[32*i +: 32]), .y(req.src_b[32*i +: 32]),
            .kind(req.kind),
            .mode(sat_illegal ? mode_wrap : req.mode),
            .cnt(req.shift_count),
            .r(r32[i])
        );
    end
    simd_lane #(.W(64)) u_qword (
        .x(req.src_a), .y(req.src_b), .kind(req.kind),
        .mode(mode_wrap), .cnt(req.shift_count), .r(r64)
    );

    // size select and legality decode
    assign sat_illegal = (req.mode != mode_wrap)
        && (req.size == lane_dword || req.size == lane_qword);
    assign lane_kind = (req.kind inside {op_add, op_sub, op_cmp_eq,
        op_cmp_gt, op_shl, op_shr_logic, op_shr_arith});
    assign lane_res = (req.size == lane_byte) ? r8 :
                      (req.size == lane_word) ? r16 :
                      (req.size == lane_dword) ? r32 : r64;

    //------------------------------------------------------------------
    // memory image, moves, multiply, pack, unpack, logical
    //------------------------------------------------------------------
    // lowest address holds the least significant byte
    always_comb begin
        load_val = '0;
        for (int i = 0; i < 8; i++) begin
            load_val[8*i +: 8] = req.mem_bytes[i];
        end
    end

    // non-lane operations
    always_comb begin
        logic signed [31:0] p;
        logic signed [31:0] q;
        logic signed [15:0] w;
        logic signed [31:0] d;
        p = '0;
        q = '0;
        w = '0;
        d = '0;
        misc_res = '0;
        case (req.kind)
            op_and: misc_res = req.src_a & req.src_b;
            op_and_not: misc_res = ~req.src_a & req.src_b;
            op_or: misc_res = req.src_a | req.src_b;
            op_xor: misc_res = req.src_a ^ req.src_b;
            move_quadword_op:
                misc_res = req.from_mem ? load_val : req.src_a;
            move_doubleword_op:
                misc_res = {32'h0000_0000,
                    req.from_mem ? load_val[31:0] : req.src_a[31:0]};
            op_mul_low, op_mul_high: begin
                for (int i = 0; i < 4; i++) begin
                    p = $signed(req.src_a[16*i +: 16])
                        * $signed(req.src_b[16*i +: 16]);
                    misc_res[16*i +: 16] = (req.kind == op_mul_low)
                        ? p[15:0] : p[31:16];
                end
            end
            op_mul_add: begin
                for (int i = 0; i < 2; i++) begin
                    p = $signed(req.src_a[32*i +: 16])
                        * $signed(req.src_b[32*i +: 16]);
                    q = $signed(req.src_a[32*i+16 +: 16])
                        * $signed(req.src_b[32*i+16 +: 16]);
                    misc_res[32*i +: 32] = 32'(p + q);
                end
            end
            op_pack_signed, op_pack_unsigned: begin
                if (req.size == lane_dword) begin
                    for (int i = 0; i < 4; i++) begin
                        d = (i < 2) ? req.src_a[32*i +: 32]
                                    : req.src_b[32*(i-2) +: 32];
                        misc_res[16*i +: 16] = (d > 32'sh0000_7fff)
                            ? 16'h7fff : (d < -32'sh0000_8000)
                            ? 16'h8000 : d[15:0];
                    end
                end else begin
                    for (int i = 0; i < 8; i++) begin
                        w = (i < 4) ? req.src_a[16*i +: 16]
                                    : req.src_b[16*(i-4) +: 16];
                        if (req.kind == op_pack_unsigned)
                            misc_res[8*i +: 8] = (w < 0) ? 8'h00 :
                                (w > 16'sh00ff) ? 8'hff : w[7:0];
                        else
                            misc_res[8*i +: 8] = (w > 16'sh007f) ? 8'h7f :
                                (w < -16'sh0080) ? 8'h80 : w[7:0];
                    end
                end
            end
            op_unpack_low, op_unpack_high: begin
                for (int i = 0; i < 4; i++) begin
                    d = (req.kind == op_unpack_high) ? 32'd4 : 32'd0;
                    case (req.size)
                        lane_byte: begin
                            misc_res[16*i +: 8] = req.src_a[8*(i+d) +: 8];
                            misc_res[16*i+8 +: 8] = req.src_b[8*(i+d) +: 8];
                        end
                        lane_word: if (i < 2) begin
                            misc_res[32*i +: 16] =
                                req.src_a[16*(i+d/2) +: 16];
                            misc_res[32*i+16 +: 16] =
                                req.src_b[16*(i+d/2) +: 16];
                        end
                        default: if (i == 0) begin
                            misc_res = {req.src_b[32*(d/4) +: 32],
                                        req.src_a[32*(d/4) +: 32]};
                        end
                    endcase
                end
            end
            default: misc_res = '0;
        endcase
    end

    assign result_next = lane_kind ? lane_res : misc_res;
    assign illegal_next = sat_illegal && lane_kind;

    //------------------------------------------------------------------
    // registered answer
    //------------------------------------------------------------------
    // result, store image and write enable, one cycle after the request
    always_ff @(posedge mclk) begin
        if (srst) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= req.valid;
            rsp_reg.illegal <= req.valid && illegal_next;
            rsp_reg.reg_write <= req.valid && !req.to_mem
                && req.kind != empty_vector_state_op && req.kind != op_nop;
            rsp_reg.data <= req.valid ? result_next : `SIMD_RESULT_RST;
            rsp_reg.store_en <= !(req.valid && req.to_mem) ?
                `SIMD_STORE_EN_RST : (req.kind == move_doubleword_op)
                ? `SIMD_DWORD_EN : `SIMD_QWORD_EN;
            for (int i = 0; i < 8; i++) begin
                rsp_reg.store_bytes[i] <= req.src_a[8*i +: 8];
            end
        end
    end

    // empty-state marker: set by the empty operation, cleared by any other valid operation except nop
    always_ff @(posedge mclk) begin
        if (srst) begin
            empty_reg <= 1'b1;
        end else if (req.valid && req.kind != op_nop) begin
            empty_reg <= (req.kind == empty_vector_state_op);
        end
    end

    assign rsp = rsp_reg;
    assign vector_state_empty = empty_reg;
    assign flags_update = 1'b0;
    assign feature_word = `SIMD_FEATURE_W'(1) << `SIMD_FEATURE_POS;
    assign op_count = 8'(`SIMD_OP_COUNT);

endmodule // packed_simd_integer_alu

// ===== pkg/packed_simd_consts.svh
//----------------------------------------------------------------------
// Purpose: width, count, feature, enable and reset constants of the packed SIMD datapath
// Assumes: included by the datapath and the assertion module
// Notes:   definitions only
//----------------------------------------------------------------------
`ifndef PACKED_SIMD_CONSTS_SVH
`define PACKED_SIMD_CONSTS_SVH

`define SIMD_DATA_W 64
`define SIMD_BYTES 8
`define SIMD_OP_COUNT 47
`define SIMD_FEATURE_POS 23
`define SIMD_FEATURE_W 32
`define SIMD_RESULT_RST 64'h0000_0000_0000_0000
`define SIMD_STORE_EN_RST 8'h00
`define SIMD_DWORD_EN 8'h0f
`define SIMD_QWORD_EN 8'hff

`endif

// ===== pkg/packed_simd_pkg.sv
//----------------------------------------------------------------------
// Purpose: types shared by the packed SIMD datapath and its users
// Assumes: operations arrive already decoded
// Notes:   lane size and overflow mode travel beside the operation
//----------------------------------------------------------------------
package packed_simd_pkg;

    // operation kinds of the decoded instruction group
    typedef enum logic [4:0] {
        op_nop, op_add, op_sub, op_cmp_eq, op_cmp_gt,
        op_and, op_and_not, op_or, op_xor,
        op_shl, op_shr_logic, op_shr_arith,
        op_mul_low, op_mul_high, op_mul_add,
        op_pack_signed, op_pack_unsigned,
        op_unpack_high, op_unpack_low,
        move_quadword_op, move_doubleword_op, empty_vector_state_op
    } op_kind_type;

    typedef enum logic [1:0] {
        lane_byte, lane_word, lane_dword, lane_qword
    } lane_size_type;

    typedef enum logic [1:0] {
        mode_wrap, mode_sat_signed, mode_sat_unsigned
    } ovf_mode_type;

    // one decoded request from the instruction decode and register file
    typedef struct packed {
        logic valid;
        op_kind_type kind;
        lane_size_type size;
        ovf_mode_type mode;
        logic from_mem;
        logic to_mem;
        logic [7:0] shift_count;
        logic [63:0] src_a;
        logic [63:0] src_b;
        logic [7:0][7:0] mem_bytes;
    } simd_req_type;

    // registered answer back to the register file and memory path
    typedef struct packed {
        logic valid;
        logic reg_write;
        logic [63:0] data;
        logic [7:0] store_en;
        logic [7:0][7:0] store_bytes;
        logic illegal;
    } simd_rsp_type;

endpackage

// ===== verification/simd_issue_model.sv
//--------------------------------------------------------------------
// Purpose: decode-side issuer in front of the packed SIMD datapath
// Assumes: the bench raises go just after an edge, together with cmd
// Notes:   idle cycles show a changing pattern on the request fields
//--------------------------------------------------------------------
`timescale 1ns/1ps
module simd_issue_model (
    input wire logic mclk,
    input wire logic srst,
    input wire logic go,
    input packed_simd_pkg::simd_req_type cmd,
    output packed_simd_pkg::simd_req_type req
);
    import packed_simd_pkg::*;
    // one request per cycle with go high; idle cycles clear valid and invert the other fields
    always_ff @(posedge mclk) begin
        if (srst) begin
            req <= '0;
        end else if (go) begin
            req <= cmd;
        end else begin
            req <= {1'b0, ~req[$bits(simd_req_type)-2:0]};
        end
    end
endmodule // simd_issue_model

// ===== verification/packed_simd_integer_alu_sva.sv
//--------------------------------------------------------------------
// Purpose: port-level checks of the packed SIMD datapath
// Assumes: one answer exactly one cycle after each request
// Notes:   bound to the datapath top module
//--------------------------------------------------------------------
`timescale 1ns/1ps
`include "packed_simd_consts.svh"
module packed_simd_integer_alu_sva (
    input wire logic mclk,
    input wire logic srst,
    input packed_simd_pkg::simd_req_type req,
    input packed_simd_pkg::simd_rsp_type rsp,
    input wire logic flags_update,
    input wire logic vector_state_empty,
    input wire logic [`SIMD_FEATURE_W-1:0] feature_word,
    input wire logic [7:0] op_count
);
    import packed_simd_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // request decodes used by the properties
    wire is_xor = req.valid && req.kind == op_xor;
    wire is_andn = req.valid && req.kind == op_and_not;
    wire is_dadd = req.valid && req.kind == op_add
        && req.size == lane_dword && req.mode == mode_wrap;
    wire [63:0] dsum = {req.src_a[63:32] + req.src_b[63:32],
        req.src_a[31:0] + req.src_b[31:0]};
    wire is_same = req.valid && req.kind == op_cmp_eq
        && req.src_a == req.src_b;
    wire is_qst = req.valid && req.kind == move_quadword_op && req.to_mem;
    wire is_empty = req.valid && req.kind == empty_vector_state_op;

    AST_LATENCY: assert property (rsp.valid == $past(req.valid))
        else $error("answer not exactly one cycle after request");
    AST_NO_FLAGS: assert property (flags_update == 1'b0)
        else $error("flag update raised");
    AST_FEATURE: assert property (feature_word == 32'h0080_0000)
        else $error("feature word wrong");
    AST_OP_COUNT: assert property (op_count == 8'h2f)
        else $error("operation count wrong");
    AST_XOR: assert property (is_xor |=>
        rsp.data == $past(req.src_a ^ req.src_b))
        else $error("xor result wrong");
    AST_AND_NOT: assert property (is_andn |=>
        rsp.data == $past(~req.src_a & req.src_b))
        else $error("and-not result wrong");
    AST_DWORD_WRAP: assert property (is_dadd |=>
        rsp.data == $past(dsum))
        else $error("dword wraparound add wrong");
    AST_CMP_SAME: assert property (is_same |=> rsp.data == '1)
        else $error("equal compare mask wrong");
    AST_STORE_Q: assert property (is_qst |=> rsp.store_en == 8'hff
        && rsp.store_bytes == $past(req.src_a) && !rsp.reg_write)
        else $error("quadword store image wrong");
    AST_EMPTY: assert property (is_empty |=> vector_state_empty)
        else $error("empty state not reported");

    C_SAT: cover property (req.valid && req.mode == mode_sat_signed);
    C_STORE: cover property (is_qst);
    C_B2B: cover property (req.valid ##1 req.valid);
endmodule // packed_simd_integer_alu_sva

bind packed_simd_integer_alu packed_simd_integer_alu_sva
    packed_simd_integer_alu_sva_i (.mclk(mclk), .srst(srst), .req(req),
    .rsp(rsp), .flags_update(flags_update),
    .vector_state_empty(vector_state_empty),
    .feature_word(feature_word), .op_count(op_count));

// ===== verification/tb_packed_simd_integer_alu.sv
//--------------------------------------------------------------------
// Purpose: self-checking bench of the packed SIMD datapath
// Assumes: answer one cycle after the datapath takes a request
// Notes:   requests pass through the issuer model, one edge late
//--------------------------------------------------------------------
`timescale 1ns/1ps
module tb_packed_simd_integer_alu;
    import packed_simd_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic go = 1'b0;
    simd_req_type cmd = '0;
    simd_req_type req;
    simd_rsp_type rsp;
    logic flags_update;
    logic vector_state_empty;
    logic [31:0] feature_word;
    logic [7:0] op_count;
    int error_cnt = 0;
    int n_tests = 0;

    initial begin
        forever #4 mclk = ~mclk;
    end

    simd_issue_model simd_issue_model_i (.mclk(mclk), .srst(srst),
        .go(go), .cmd(cmd), .req(req));
    packed_simd_integer_alu packed_simd_integer_alu_i (.mclk(mclk),
        .srst(srst), .req(req), .rsp(rsp), .flags_update(flags_update),
        .vector_state_empty(vector_state_empty),
        .feature_word(feature_word), .op_count(op_count));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic set_op(input op_kind_type k, input lane_size_type s,
            input ovf_mode_type m, input logic [63:0] a, b);
        cmd = '{valid: 1'b1, kind: k, size: s, mode: m, src_a: a,
            src_b: b, default: '0};
    endtask

    // issue cmd once and wait, bounded, for its answer
    task automatic fire();
        int n;
        go = 1'b1;
        @(posedge mclk);
        #1 go = 1'b0;
        n = 0;
        while (rsp.valid !== 1'b1) begin
            @(posedge mclk);
            #1 n++;
            if (n > 4) begin
                error_cnt++;
                $display("Error at %0t ns: no answer", $time);
                results();
            end
        end
    endtask

    task automatic xop(input op_kind_type k, input lane_size_type s,
            input ovf_mode_type m, input logic [63:0] a, b, exp);
        set_op(k, s, m, a, b);
        fire();
        check(rsp.data, exp);
    endtask

    task automatic xsh(input op_kind_type k, input lane_size_type s,
            input logic [7:0] c, input logic [63:0] a, exp);
        set_op(k, s, mode_wrap, a, 64'h0);
        cmd.shift_count = c;
        fire();
        check(rsp.data, exp);
    endtask

    task automatic t_consts();
        check(feature_word, 32'h0080_0000);
        check(op_count, 8'h2f);
        check(flags_update, 1'b0);
        check(rsp.valid, 1'b0);
        check(vector_state_empty, 1'b1);
        $display("test consts done");
    endtask

    task automatic t_saturate();
        xop(op_add, lane_word, mode_sat_signed, 64'h0001ffff80007fff,
            64'h0002ffffffff0001, 64'h0003fffe80007fff);
        xop(op_sub, lane_word, mode_sat_signed, 64'h7fff8000,
            64'hffff0001, 64'h7fff8000);
        xop(op_add, lane_byte, mode_sat_signed, 64'h10807f,
            64'h20ff01, 64'h30807f);
        xop(op_add, lane_byte, mode_sat_unsigned, 64'h10ff,
            64'h2001, 64'h30ff);
        xop(op_sub, lane_byte, mode_sat_unsigned, 64'h0500,
            64'h0301, 64'h0200);
        xop(op_add, lane_word, mode_sat_unsigned, 64'h1ffff,
            64'h10001, 64'h2ffff);
        xop(op_sub, lane_word, mode_sat_unsigned, 64'h50000,
            64'h30001, 64'h20000);
        check(flags_update, 1'b0);
        $display("test saturate done");
    endtask

    task automatic t_wrap();
        xop(op_add, lane_byte, mode_wrap, 64'h01ff, 64'h01,
            64'h0100);
        xop(op_sub, lane_word, mode_wrap, 64'h50000, 64'h1, 64'h5ffff);
        xop(op_add, lane_dword, mode_wrap, 64'h1ffffffff, 64'h1,
            64'h100000000);
        check(rsp.illegal, 1'b0);
        check(rsp.reg_write, 1'b1);
        xop(op_add, lane_dword, mode_sat_signed, 64'h7fffffff, 64'h1,
            64'h80000000);
        check(rsp.illegal, 1'b1);
        $display("test wrap done");
    endtask

    task automatic t_convert();
        xsh(op_shl, lane_word, 8'h04, 64'h7ff08001, 64'hff000010);
        xop(op_pack_signed, lane_word, mode_sat_signed,
            64'h00000100ff000005, 64'h0, 64'h007f8005);
        xop(op_pack_unsigned, lane_word, mode_sat_unsigned,
            64'h00000100ff000005, 64'h0, 64'h00ff0005);
        xop(op_pack_signed, lane_dword, mode_sat_signed,
            64'h8000000000010000, 64'hfffffffe, 64'h0000fffe80007fff);
        xop(op_unpack_low, lane_byte, mode_wrap, 64'h04030201,
            64'h0d0c0b0a, 64'h0d040c030b020a01);
        xop(op_unpack_high, lane_word, mode_wrap,
            64'h4444333300000000, 64'hbbbbaaaa00000000, 64'hbbbb4444aaaa3333);
        xop(op_mul_low, lane_word, mode_wrap, 64'hffff0100,
            64'h00020300, 64'hfffe0000);
        xop(op_mul_high, lane_word, mode_wrap, 64'hffff0100,
            64'h00020300, 64'hffff0003);
        xop(op_mul_add, lane_word, mode_wrap, 64'h0002ffff,
            64'h00050004, 64'h6);
        $display("test convert done");
    endtask

    task automatic t_logic_cmp();
        xop(op_and, lane_qword, mode_wrap, 64'hf0f01234ffff0000,
            64'hff0000ff0f0faaaa, 64'hf00000340f0f0000);
        xop(op_and_not, lane_qword, mode_wrap, 64'hf0f01234ffff0000,
            64'hff0000ff0f0faaaa, 64'h0f0000cb0000aaaa);
        xop(op_or, lane_qword, mode_wrap, 64'hf0f01234ffff0000,
            64'hff0000ff0f0faaaa, 64'hfff012ffffffaaaa);
        xop(op_xor, lane_qword, mode_wrap, 64'hf0f01234ffff0000,
            64'hff0000ff0f0faaaa, 64'h0ff012cbf0f0aaaa);
        xop(op_cmp_eq, lane_byte, mode_wrap, 64'h0102030405060708,
            64'h0102000005060000, 64'hffff0000ffff0000);
        xop(op_cmp_eq, lane_word, mode_wrap, 64'h1234, 64'h1234, '1);
        xop(op_cmp_gt, lane_byte, mode_wrap, 64'h7f8001,
            64'h807f00, 64'hff00ff);
        $display("test logic and compare done");
    endtask

    task automatic t_shift();
        xsh(op_shr_arith, lane_word, 8'h04, 64'h7ff08000, 64'h07fff800);
        xsh(op_shr_logic, lane_word, 8'h04, 64'h7ff08000, 64'h07ff0800);
        xsh(op_shr_arith, lane_dword, 8'h04, 64'h8000000000000010,
            64'hf800000000000001);
        xsh(op_shr_arith, lane_word, 8'h10, 64'h7ff08000, 64'h0000ffff);
        $display("test shift done");
    endtask

    task automatic t_memory();
        set_op(move_quadword_op, lane_qword, mode_wrap,
            64'h8877665544332211, 0);
        cmd.to_mem = 1'b1;
        fire();
        check(rsp.store_en, 8'hff);
        check(rsp.store_bytes[0], 8'h11);
        check(rsp.store_bytes, 64'h8877665544332211);
        check(rsp.reg_write, 1'b0);
        set_op(move_quadword_op, lane_qword, mode_wrap, 64'h0, 64'h0);
        cmd.from_mem = 1'b1;
        cmd.mem_bytes = 64'h8877665544332211;
        fire();
        check(rsp.data, 64'h8877665544332211);
        cmd.kind = move_doubleword_op;
        fire();
        check(rsp.data, 64'h44332211);
        set_op(move_doubleword_op, lane_dword, mode_wrap, 64'h1234, 0);
        cmd.to_mem = 1'b1;
        fire();
        check(rsp.store_en, 8'h0f);
        $display("test memory done");
    endtask

    task automatic t_empty_b2b();
        set_op(empty_vector_state_op, lane_qword, mode_wrap, 64'h0, 64'h0);
        fire();
        check(vector_state_empty, 1'b1);
        set_op(op_add, lane_byte, mode_wrap, 64'h0101, 64'h0101);
        go = 1'b1;
        @(posedge mclk);
        #1 set_op(op_sub, lane_byte, mode_wrap, 64'h0505, 64'h0102);
        @(posedge mclk);
        #1 go = 1'b0;
        check(rsp.data, 64'h0202);
        @(posedge mclk);
        #1 check(rsp.data, 64'h0403);
        $display("test empty and back-to-back done");
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        #1 srst = 1'b0;
        t_consts();
        t_saturate();
        t_wrap();
        t_logic_cmp();
        t_shift();
        t_convert();
        t_memory();
        t_empty_b2b();
        results();
    end
endmodule // tb_packed_simd_integer_alu
